// >>> core/abt_params.svh
// Purpose: offsets, field positions, masks and timing counts of the upper register bank
// Assumes: 6-bit word index on the register port, 16-bit data
// Notes: masks mark the bits that store; other bits read as zero
`ifndef ABT_PARAMS_SVH
`define ABT_PARAMS_SVH
// register offsets
`define ABT_A_CFG4 6'h08
`define ABT_A_CFG5 6'h09
`define ABT_A_DSTK 6'h0a
`define ABT_A_FTR_A 6'h0b
`define ABT_A_FTR_B 6'h0c
`define ABT_A_LCMD 6'h0d
`define ABT_A_RTSW 6'h0e
`define ABT_A_RTBIT 6'h0f
`define ABT_A_CFG6 6'h18
`define ABT_A_CFG7 6'h19
`define ABT_A_COND 6'h1b
`define ABT_A_BIST 6'h1c
`define ABT_A_MSK2 6'h1d
`define ABT_A_ISR2 6'h1e
`define ABT_A_QPTR 6'h1f
// storing bits per register
`define ABT_M_CFG5 16'h3fff
`define ABT_M_CFG6 16'hbff4
`define ABT_M_CFG7 16'hfc1f
`define ABT_M_RTSW 16'h071f
`define ABT_M_RTBIT 16'hfeff
`define ABT_M_MSK2 16'h7ffe
`define ABT_RST_WORD 16'h0000
// field positions
`define ABT_B_CFG4_LATCH 3
`define ABT_B_CFG5_INH_A 13
`define ABT_B_CFG5_INH_B 12
`define ABT_B_CFG5_TRANSP 6
`define ABT_B_CFG6_ISQ_EN 6
`define ABT_B_CFG6_NO_VALID 7
`define ABT_B_CFG6_NO_INVALID 8
// frame time resolution
`define ABT_CLK_NS 8
`define ABT_FT_LSB_US 100
`define ABT_FT_LSB_CYC ((`ABT_FT_LSB_US * 1000) / `ABT_CLK_NS)
`endif

// >>> core/abt_pkg.sv
// Purpose: shared types of the upper register bank
// Assumes: nothing beyond the params header
// Notes: numbers live in abt_params.svh
package abt_pkg;
  typedef logic [5:0] abt_addr_t;
  typedef logic [15:0] abt_word_t;
endpackage : abt_pkg

// >>> core/abt_upper_regs.sv
// Purpose: upper host register bank of a dual-redundant serial-bus terminal
// Assumes: register port decoded from the serial host port, same clock
// Notes: core-side inputs come from logic on clk and are not synchronised
//
// What this block does
// - frame time counts 100 us per LSB
// - condition reads zero unless enhanced controller online
// - flag write: bit 8+n clears, n sets
// - status word bits 15..11 zero, fixed layout
// - timeout select, gap check, broadcast disable
// - address latch control, address, parity
// - separate transmitter inhibit per channel
// - retry bus selection for two retries
// - test mode field, address latch select
// - second status read-only, master and chain
// - half-full rollover events at bits 9..6
// - circular buffer enable and size field
// - queue enable, valid/invalid suppression
// - memory base bits 15..10, 9..5 reserved
// - halt, response time, sync, watchdog, select
// - self-test flags and model identifier
// - queue base and position fields
// - terminal block status word layout
// - controller block status word layout
// - terminal self-test word layout
// - stored command word layout
// - chain bit shows first status pending
// - event bit sits at its mask bit
`timescale 1ns/1ps
`include "abt_params.svh"

module abt_upper_regs
  import abt_pkg::*;
#(
  parameter int FT_LSB_CYC = `ABT_FT_LSB_CYC,
  parameter logic [3:0] MODEL_ID = 4'h1 // arbitrary value
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire abt_addr_t addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire abt_word_t wdata,
  output abt_word_t rdata,
  // terminal address pins: address 4..0 then parity
  input wire logic [5:0] rt_addr_pin,
  // protocol engine state
  input wire logic bc_online,
  input wire logic [6:0] bc_cond,
  input wire logic frame_run,
  input wire logic [14:1] evt2,
  input wire logic isr1_pend,
  input wire logic [11:0] bist_flags,
  input wire logic rtsw_ld,
  input wire abt_word_t rtsw_in,
  input wire logic rtbit_ld,
  input wire abt_word_t rtbit_in,
  input wire logic q_push,
  input wire logic q_msg_valid,
  // message completion
  input wire logic msg_done,
  input wire logic end_of_message_flag,
  input wire logic start_of_message_flag,
  input wire logic msg_chan_b,
  input wire logic msg_err,
  input wire logic [11:0] msg_cond,
  input wire logic [1:0] retry_cnt,
  input wire logic masked_set,
  input wire logic loop_fail,
  input wire logic [4:0] cmd_rta,
  input wire logic cmd_tx,
  input wire logic [4:0] cmd_sa,
  input wire logic [4:0] cmd_cnt,
  // configuration towards the core
  output abt_word_t cfg4,
  output abt_word_t cfg5,
  output abt_word_t cfg6,
  output abt_word_t cfg7,
  output abt_word_t data_stack,
  output abt_word_t queue_ptr,
  output abt_word_t frame_time,
  output logic [4:0] rt_addr,
  output logic rt_addr_perr,
  output logic tx_inh_a,
  output logic tx_inh_b,
  output logic event_master,
  // words for shared memory
  output abt_word_t rt_bsw,
  output abt_word_t bc_bsw,
  output abt_word_t cmd_word
);

  logic rstn_meta_ff;
  logic rstn_sync_ff;
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;
  logic first_ff;
  abt_word_t rdata_ff;
  abt_word_t cfg4_ff;
  abt_word_t cfg5_ff;
  abt_word_t cfg6_ff;
  abt_word_t cfg7_ff;
  abt_word_t dstk_ff;
  abt_word_t ftr_ff;
  logic [15:0] pre_ff;
  abt_word_t lcmd_ff;
  abt_word_t rtsw_ff;
  abt_word_t rtbit_ff;
  abt_word_t msk2_ff;
  abt_word_t qptr_ff;
  logic [7:0] gpf_ff;
  logic [7:0] nxt_gpf;
  logic [14:1] isr_st_ff;
  logic [14:1] nxt_isr;
  logic [5:0] rta_ff;
  abt_word_t rt_bsw_ff;
  abt_word_t bc_bsw_ff;
  abt_word_t cmd_ff;
  wire [15:0] nxt_cmd;

  // assertions below share this clock and the synchronised reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn_sync_ff);

  // reset release through two flops; asserts at once, leaves on clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstn_meta_ff <= 1'b0;
      rstn_sync_ff <= 1'b0;
    end else begin
      rstn_meta_ff <= 1'b1;
      rstn_sync_ff <= rstn_meta_ff;
    end
  end

  // address pins arrive unsynchronised; no reset, so the first capture
  // after release sees settled pins rather than a cleared copy
  always_ff @(posedge clk) begin
    if (ce) begin
      pin_meta_ff <= rt_addr_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // write decode
  wire hit_cfg4 = wr_en && (addr == `ABT_A_CFG4);
  wire hit_cfg5 = wr_en && (addr == `ABT_A_CFG5);
  wire hit_dstk = wr_en && (addr == `ABT_A_DSTK);
  wire hit_ftr = wr_en && ((addr == `ABT_A_FTR_A) || (addr == `ABT_A_FTR_B));
  wire hit_lcmd = wr_en && (addr == `ABT_A_LCMD);
  wire hit_rtsw = wr_en && (addr == `ABT_A_RTSW);
  wire hit_rtbit = wr_en && (addr == `ABT_A_RTBIT);
  wire hit_cfg6 = wr_en && (addr == `ABT_A_CFG6);
  wire hit_cfg7 = wr_en && (addr == `ABT_A_CFG7);
  wire hit_cond = wr_en && (addr == `ABT_A_COND);
  wire hit_msk2 = wr_en && (addr == `ABT_A_MSK2);
  wire hit_qptr = wr_en && (addr == `ABT_A_QPTR);
  wire rd_isr2 = rd_en && (addr == `ABT_A_ISR2);

  // configuration words; masks keep reserved bits at zero
  always_ff @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      cfg4_ff <= `ABT_RST_WORD;
      cfg5_ff <= `ABT_RST_WORD;
      cfg6_ff <= `ABT_RST_WORD;
      cfg7_ff <= `ABT_RST_WORD;
      dstk_ff <= `ABT_RST_WORD;
      msk2_ff <= `ABT_RST_WORD;
    end else if (ce) begin
      if (hit_cfg4) cfg4_ff <= wdata;
      if (hit_cfg5) cfg5_ff <= wdata & `ABT_M_CFG5;
      if (hit_cfg6) cfg6_ff <= wdata & `ABT_M_CFG6;
      if (hit_cfg7) cfg7_ff <= wdata & `ABT_M_CFG7;
      if (hit_dstk) dstk_ff <= wdata;
      if (hit_msk2) msk2_ff <= wdata & `ABT_M_MSK2;
    end
  end

  // frame time: prescaler makes one LSB per 100 us while a frame runs
  wire pre_wrap = (pre_ff == 16'(FT_LSB_CYC - 1));
  wire ft_tick = ce && frame_run && !hit_ftr && pre_wrap && (ftr_ff != 16'h0000);
  always_ff @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      ftr_ff <= `ABT_RST_WORD;
      pre_ff <= 16'h0000;
    end else if (ce) begin
      if (hit_ftr) begin
        ftr_ff <= wdata;
        pre_ff <= 16'h0000;
      end else if (frame_run && ftr_ff != 16'h0000) begin
        pre_ff <= pre_wrap ? 16'h0000 : 16'(pre_ff + 16'h0001);
        if (pre_wrap) ftr_ff <= 16'(ftr_ff - 16'h0001);
      end
    end
  end

  // status and self-test words: core load wins so no event is lost
  always_ff @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      rtsw_ff <= `ABT_RST_WORD;
      rtbit_ff <= `ABT_RST_WORD;
      lcmd_ff <= `ABT_RST_WORD;
    end else if (ce) begin
      if (rtsw_ld) rtsw_ff <= rtsw_in & `ABT_M_RTSW;
      else if (hit_rtsw) rtsw_ff <= wdata & `ABT_M_RTSW;
      if (rtbit_ld) rtbit_ff <= rtbit_in & `ABT_M_RTBIT;
      else if (hit_rtbit) rtbit_ff <= wdata & `ABT_M_RTBIT;
      if (msg_done) lcmd_ff <= nxt_cmd;
      else if (hit_lcmd) lcmd_ff <= wdata;
    end
  end

  // flag set and clear per bit; set beats clear in the same write
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      assign nxt_gpf[gi] = hit_cond ? (wdata[gi] | (gpf_ff[gi] & ~wdata[8 + gi]))
                                    : gpf_ff[gi];
    end
    // sticky events, cleared by reading; an arriving event survives the read
    for (gi = 1; gi < 15; gi++) begin : g_evt
      assign nxt_isr[gi] = evt2[gi] | (isr_st_ff[gi] & ~rd_isr2);
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      gpf_ff <= 8'h00;
      isr_st_ff <= 14'h0000;
    end else if (ce) begin
      gpf_ff <= nxt_gpf;
      isr_st_ff <= nxt_isr;
    end
  end

  // queue pointer: position steps on each entry the config admits
  wire q_allow = q_msg_valid ? !cfg6_ff[`ABT_B_CFG6_NO_VALID] : !cfg6_ff[`ABT_B_CFG6_NO_INVALID];
  wire q_step = q_push && cfg6_ff[`ABT_B_CFG6_ISQ_EN] && q_allow;
  wire [5:0] q_pos_inc = 6'(qptr_ff[5:0] + 6'h01);
  always_ff @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) qptr_ff <= `ABT_RST_WORD;
    else if (ce) begin
      if (hit_qptr) qptr_ff <= wdata;
      else if (q_step) qptr_ff <= {qptr_ff[15:6], q_pos_inc};
    end
  end

  // terminal address: from config when latch selected, else pins
  // pins are caught once after reset release, then followed if transparent
  wire rta_from_cfg = cfg4_ff[`ABT_B_CFG4_LATCH];
  wire rta_ld = rta_from_cfg || cfg5_ff[`ABT_B_CFG5_TRANSP] || first_ff;
  wire [5:0] rta_src = rta_from_cfg ? cfg5_ff[5:0] : pin_sync_ff;
  always_ff @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      first_ff <= 1'b1;
      rta_ff <= 6'h00;
    end else if (ce) begin
      first_ff <= 1'b0;
      if (rta_ld) rta_ff <= rta_src;
    end
  end

  // memory words assembled at message end
  assign nxt_cmd = {cmd_rta, cmd_tx, cmd_sa, cmd_cnt};
  wire [15:0] nxt_rt_bsw = {end_of_message_flag, start_of_message_flag,
                            msg_chan_b, msg_err, msg_cond};
  wire [15:0] nxt_bc_bsw = {end_of_message_flag, start_of_message_flag,
                            msg_chan_b, msg_err, msg_cond[11:9], loop_fail,
                            masked_set, retry_cnt, msg_cond[4:0]};
  always_ff @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      rt_bsw_ff <= `ABT_RST_WORD;
      bc_bsw_ff <= `ABT_RST_WORD;
      cmd_ff <= `ABT_RST_WORD;
    end else if (ce && msg_done) begin
      rt_bsw_ff <= nxt_rt_bsw;
      bc_bsw_ff <= nxt_bc_bsw;
      cmd_ff <= nxt_cmd;
    end
  end

  // read values; chain bit mirrors first status pending
  wire irq_any = (|(isr_st_ff & msk2_ff[14:1])) | isr1_pend;
  wire [15:0] isr2_val = {irq_any, isr_st_ff, isr1_pend};
  wire [15:0] cond_val = bc_online ? {1'b1, bc_cond, gpf_ff} : 16'h0000;
  wire [15:0] bist_val = {bist_flags, MODEL_ID};

  // read select; unmapped and write-only offsets return zero
  wire [15:0] rd_val =
      ({16{addr == `ABT_A_CFG4}} & cfg4_ff) |
      ({16{addr == `ABT_A_CFG5}} & cfg5_ff) |
      ({16{addr == `ABT_A_DSTK}} & dstk_ff) |
      ({16{addr == `ABT_A_FTR_A}} & ftr_ff) |
      ({16{addr == `ABT_A_FTR_B}} & ftr_ff) |
      ({16{addr == `ABT_A_LCMD}} & lcmd_ff) |
      ({16{addr == `ABT_A_RTSW}} & rtsw_ff) |
      ({16{addr == `ABT_A_RTBIT}} & rtbit_ff) |
      ({16{addr == `ABT_A_CFG6}} & cfg6_ff) |
      ({16{addr == `ABT_A_CFG7}} & cfg7_ff) |
      ({16{addr == `ABT_A_COND}} & cond_val) |
      ({16{addr == `ABT_A_BIST}} & bist_val) |
      ({16{addr == `ABT_A_MSK2}} & msk2_ff) |
      ({16{addr == `ABT_A_ISR2}} & isr2_val) |
      ({16{addr == `ABT_A_QPTR}} & qptr_ff);

  // read data held until the next read
  always_ff @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) rdata_ff <= `ABT_RST_WORD;
    else if (ce && rd_en) rdata_ff <= rd_val;
  end

  // outputs
  assign rdata = rdata_ff;
  assign cfg4 = cfg4_ff;
  assign cfg5 = cfg5_ff;
  assign cfg6 = cfg6_ff;
  assign cfg7 = cfg7_ff;
  assign data_stack = dstk_ff;
  assign queue_ptr = qptr_ff;
  assign frame_time = ftr_ff;
  assign rt_addr = rta_ff[5:1];
  assign rt_addr_perr = ~^rta_ff; // odd parity over address and parity bit
  assign tx_inh_a = cfg5_ff[`ABT_B_CFG5_INH_A];
  assign tx_inh_b = cfg5_ff[`ABT_B_CFG5_INH_B];
  assign event_master = irq_any;
  assign rt_bsw = rt_bsw_ff;
  assign bc_bsw = bc_bsw_ff;
  assign cmd_word = cmd_ff;

  // checks
  a_cond_offline: assert property (ce && rd_en && addr == `ABT_A_COND && !bc_online
    |=> rdata == 16'h0000) else $error("condition read not zero while offline");
  a_cond_online: assert property (ce && rd_en && addr == `ABT_A_COND && bc_online
    |=> rdata[15] && rdata[7:0] == $past(gpf_ff)) else $error("condition read wrong");
  a_flag_set: assert property (ce && hit_cond && wdata[0]
    |=> gpf_ff[0]) else $error("flag 0 not set");
  a_flag_clear: assert property (ce && hit_cond && wdata[8] && !wdata[0]
    |=> !gpf_ff[0]) else $error("flag 0 not cleared");
  a_status_zero: assert property (rtsw_ff[15:11] == 5'h00)
    else $error("status word top bits set");
  a_master_bit: assert property (ce && rd_isr2
    |=> rdata[15] == $past(irq_any)) else $error("master bit wrong");
  a_chain_bit: assert property (ce && rd_isr2
    |=> rdata[0] == $past(isr1_pend)) else $error("chain bit wrong");
  a_event_sticky: assert property (ce && evt2[9]
    |=> isr_st_ff[9] [*1]) else $error("half-full event lost");
  a_frame_step: assert property (ft_tick
    |=> ftr_ff == 16'($past(ftr_ff) - 16'h0001)) else $error("frame time step wrong");
  a_queue_step: assert property (ce && q_step && !hit_qptr
    |=> qptr_ff[5:0] == $past(q_pos_inc)) else $error("queue position not stepped");
  a_queue_off: assert property (ce && q_push && !cfg6_ff[`ABT_B_CFG6_ISQ_EN] && !hit_qptr
    |=> $stable(qptr_ff)) else $error("queue moved while disabled");
  a_rsvd_zero: assert property (cfg7_ff[9:5] == 5'h00 && cfg5_ff[15:14] == 2'h0)
    else $error("reserved bits stored");
  a_addr_hold: assert property (ce && !first_ff && !rta_from_cfg
    && !cfg5_ff[`ABT_B_CFG5_TRANSP] |=> $stable(rta_ff))
    else $error("terminal address moved while held");
  a_addr_latch: assert property (ce && rta_from_cfg
    |=> rta_ff == $past(cfg5_ff[5:0])) else $error("address not taken from config");
  a_bsw_flags: assert property (ce && msg_done
    |=> rt_bsw[15:12] == $past({end_of_message_flag, start_of_message_flag,
                                msg_chan_b, msg_err}))
    else $error("block status flags wrong");
  a_cmd_fields: assert property (ce && msg_done
    |=> cmd_word[15:10] == $past({cmd_rta, cmd_tx})) else $error("command word fields wrong");
  a_queue_base: assert property (ce && q_step && !hit_qptr
    |=> qptr_ff[15:6] == $past(qptr_ff[15:6])) else $error("queue base moved");
  a_flag_keep: assert property (ce && !hit_cond
    |=> gpf_ff == $past(gpf_ff)) else $error("flags changed without a write");

  c_flag_write: cover property (ce && hit_cond ##1 gpf_ff != 8'h00);
  c_chain_read: cover property (ce && rd_isr2 && isr1_pend);
  c_frame_end: cover property (ft_tick && ftr_ff == 16'h0001);
  c_queue_wrap: cover property (ce && q_step && qptr_ff[5:0] == 6'h3f);
  c_evt_read: cover property (ce && rd_isr2 && isr_st_ff[9:6] != 4'h0);

endmodule : abt_upper_regs

// >>> core/_unused_guard.sv
`timescale 1ns/1ps
// Purpose: none
// Assumes: none
// Notes: empty

// >>> testbench/abt_host_model.sv
// Purpose: host side of the register port, one request at a time
// Assumes: request taken at the rising edge with its strobe high
// Notes: released address and data show inverted values, so stale data never passes
`timescale 1ns/1ps

module abt_host_model
  import abt_pkg::*;
(
  // clock
  input wire logic clk,
  // register port towards the bank
  output abt_addr_t addr,
  output logic wr_en,
  output logic rd_en,
  output abt_word_t wdata,
  input wire abt_word_t rdata
);
  // idle bus at time zero
  initial begin
    addr = 6'h3f;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 16'h0000;
  end

  // one write, strobe dropped after the taking edge
  task automatic wr(input abt_addr_t a, input abt_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr

  // one read; data is registered, so it is taken one edge after the request
  task automatic rd(input abt_addr_t a, output abt_word_t d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    #1;
    d = rdata;
  endtask : rd
endmodule : abt_host_model

// >>> testbench/tb.sv
// Purpose: self-checking bench of the upper register bank
// Assumes: short frame prescaler of 4 cycles
// Notes: expected words are built by hand from the field layouts
`timescale 1ns/1ps
`include "abt_params.svh"
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end

module tb
  import abt_pkg::*;
();
  localparam int FT = 4;
  localparam logic [3:0] MID = 4'h6; // arbitrary
  logic clk, rstn, ce, wr_en, rd_en;
  abt_addr_t addr;
  abt_word_t wdata, rdata, rtsw_in, rtbit_in, rv;
  logic [5:0] rt_addr_pin;
  logic bc_online, frame_run, isr1_pend, rtsw_ld, rtbit_ld, q_push, q_msg_valid, msg_done;
  logic [6:0] bc_cond;
  logic [14:1] evt2;
  logic [11:0] bist_flags, msg_cond;
  logic end_of_message_flag, start_of_message_flag, msg_chan_b, msg_err, masked_set;
  logic loop_fail, cmd_tx, rt_addr_perr, tx_inh_a, tx_inh_b, event_master;
  logic [1:0] retry_cnt;
  logic [4:0] cmd_rta, cmd_sa, cmd_cnt, rt_addr;
  abt_word_t cfg4, cfg5, cfg6, cfg7, data_stack, queue_ptr, frame_time, rt_bsw, bc_bsw, cmd_word;
  int mismatches = 0;
  int compares = 0;

  abt_upper_regs #(.FT_LSB_CYC(FT), .MODEL_ID(MID)) u_dut (
    .clk, .rstn, .ce, .addr, .wr_en, .rd_en, .wdata, .rdata, .rt_addr_pin, .bc_online,
    .bc_cond, .frame_run, .evt2, .isr1_pend, .bist_flags, .rtsw_ld, .rtsw_in, .rtbit_ld,
    .rtbit_in, .q_push, .q_msg_valid, .msg_done, .end_of_message_flag, .start_of_message_flag,
    .msg_chan_b, .msg_err, .msg_cond, .retry_cnt, .masked_set, .loop_fail, .cmd_rta, .cmd_tx,
    .cmd_sa, .cmd_cnt, .cfg4, .cfg5, .cfg6, .cfg7, .data_stack, .queue_ptr, .frame_time,
    .rt_addr, .rt_addr_perr, .tx_inh_a, .tx_inh_b, .event_master, .rt_bsw, .bc_bsw, .cmd_word
  );
  abt_host_model u_host (.clk, .addr, .wr_en, .rd_en, .wdata, .rdata);

  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // read one register and compare with the expected word
  task automatic rd_chk(input abt_addr_t a, input abt_word_t e);
    u_host.rd(a, rv);
    `CHK(rv, e)
  endtask : rd_chk

  // let the edge after a request land before looking at outputs
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // pin address after reset, hold, transparent follow, frozen enable
  task automatic t_pins();
    settle();
    `CHK({rt_addr, rt_addr_perr}, 6'h0a)
    @(posedge clk);
    rt_addr_pin <= 6'h15;
    repeat (4) settle();
    `CHK(rt_addr, 5'h05)
    u_host.wr(`ABT_A_CFG5, 16'h0040);
    repeat (2) settle();
    `CHK({rt_addr, rt_addr_perr}, 6'h14)
    @(posedge clk);
    ce <= 1'b0;
    u_host.wr(`ABT_A_CFG5, 16'h3000);
    ce <= 1'b1;
    settle();
    `CHK(cfg5, 16'h0040)
    `CHK({tx_inh_a, tx_inh_b}, 2'b00)
    u_host.wr(`ABT_A_DSTK, 16'hbeef);
    rd_chk(`ABT_A_DSTK, 16'hbeef);
    `CHK(data_stack, 16'hbeef)
    $display("test pins done");
  endtask : t_pins

  task automatic t_cfg();
    u_host.wr(`ABT_A_CFG4, 16'hffff);
    rd_chk(`ABT_A_CFG4, 16'hffff);
    u_host.wr(`ABT_A_CFG5, 16'hffff);
    rd_chk(`ABT_A_CFG5, 16'h3fff);
    u_host.wr(`ABT_A_CFG5, 16'h203e);
    settle();
    `CHK({tx_inh_a, tx_inh_b}, 2'b10)
    `CHK(rt_addr, 5'h1f)
    rd_chk(`ABT_A_CFG5, 16'h203e);
    u_host.wr(`ABT_A_CFG6, 16'hffff);
    rd_chk(`ABT_A_CFG6, 16'hbff4);
    u_host.wr(`ABT_A_CFG7, 16'hffff);
    rd_chk(`ABT_A_CFG7, 16'hfc1f);
    u_host.wr(`ABT_A_CFG7, 16'h001f);
    rd_chk(`ABT_A_CFG7, 16'h001f);
    `CHK(cfg4, 16'hffff)
    `CHK(cfg5, 16'h203e)
    `CHK(cfg6, 16'hbff4)
    `CHK(cfg7, 16'h001f)
    rd_chk(6'h1a, 16'h0000);
    $display("test cfg done");
  endtask : t_cfg

  task automatic t_cond();
    u_host.wr(`ABT_A_COND, 16'h00a5);
    rd_chk(`ABT_A_COND, 16'h0000);
    @(posedge clk);
    bc_online <= 1'b1;
    bc_cond <= 7'h55;
    rd_chk(`ABT_A_COND, 16'hd5a5);
    u_host.wr(`ABT_A_COND, 16'h0500);
    rd_chk(`ABT_A_COND, 16'hd5a0);
    $display("test cond done");
  endtask : t_cond

  // sticky events, chain bit, read-clear and masking
  task automatic t_evt();
    u_host.wr(`ABT_A_MSK2, 16'hffff);
    rd_chk(`ABT_A_MSK2, 16'h7ffe);
    @(posedge clk);
    evt2[9:6] <= 4'hf;
    isr1_pend <= 1'b1;
    @(posedge clk);
    evt2 <= '0;
    settle();
    `CHK(event_master, 1'b1)
    rd_chk(`ABT_A_ISR2, 16'h83c1);
    rd_chk(`ABT_A_ISR2, 16'h8001);
    @(posedge clk);
    isr1_pend <= 1'b0;
    u_host.wr(`ABT_A_MSK2, 16'h0000);
    @(posedge clk);
    evt2[8] <= 1'b1;
    @(posedge clk);
    evt2 <= '0;
    settle();
    `CHK(event_master, 1'b0)
    u_host.wr(`ABT_A_ISR2, 16'hffff);
    rd_chk(`ABT_A_ISR2, 16'h0100);
    $display("test events done");
  endtask : t_evt

  task automatic t_ft();
    @(posedge clk);
    frame_run <= 1'b1;
    u_host.wr(`ABT_A_FTR_A, 16'h0005);
    settle();
    `CHK(frame_time, 16'h0005)
    repeat (FT) @(posedge clk);
    #1;
    `CHK(frame_time, 16'h0004)
    repeat (FT) @(posedge clk);
    frame_run <= 1'b0;
    #1;
    `CHK(frame_time, 16'h0003)
    rd_chk(`ABT_A_FTR_B, 16'h0003);
    $display("test frame done");
  endtask : t_ft

  task automatic t_words();
    @(posedge clk);
    {end_of_message_flag, start_of_message_flag, msg_chan_b, msg_err} <= 4'ha;
    {msg_cond, retry_cnt, masked_set, loop_fail} <= {12'ha5c, 2'b10, 1'b1, 1'b0};
    {cmd_rta, cmd_tx, cmd_sa, cmd_cnt} <= {5'h15, 1'b1, 5'h0a, 5'h13};
    {msg_done, rtsw_ld, rtbit_ld} <= 3'b111;
    {rtsw_in, rtbit_in} <= {16'hffff, 16'hffff};
    @(posedge clk);
    {msg_done, rtsw_ld, rtbit_ld} <= 3'b000;
    #1;
    `CHK(rt_bsw, 16'haa5c)
    `CHK(bc_bsw, 16'haadc)
    `CHK(cmd_word, 16'had53)
    rd_chk(`ABT_A_LCMD, 16'had53);
    u_host.wr(`ABT_A_LCMD, 16'h1234);
    rd_chk(`ABT_A_LCMD, 16'h1234);
    rd_chk(`ABT_A_RTSW, 16'h071f);
    rd_chk(`ABT_A_RTBIT, 16'hfeff);
    u_host.wr(`ABT_A_BIST, 16'h0000);
    rd_chk(`ABT_A_BIST, {12'ha5c, MID});
    $display("test words done");
  endtask : t_words

  // queue position steps, wraps and honours suppression
  task automatic t_queue();
    u_host.wr(`ABT_A_CFG6, 16'h0040);
    u_host.wr(`ABT_A_QPTR, 16'h12bf);
    @(posedge clk);
    {q_push, q_msg_valid} <= 2'b11;
    @(posedge clk);
    q_push <= 1'b0;
    rd_chk(`ABT_A_QPTR, 16'h1280);
    u_host.wr(`ABT_A_CFG6, 16'h00c0);
    @(posedge clk);
    q_push <= 1'b1;
    @(posedge clk);
    q_msg_valid <= 1'b0;
    @(posedge clk);
    q_push <= 1'b0;
    rd_chk(`ABT_A_QPTR, 16'h1281);
    `CHK(queue_ptr, 16'h1281)
    $display("test queue done");
  endtask : t_queue

  // watchdog, far beyond the roughly 160 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    {rstn, ce, bc_online, frame_run, isr1_pend, rtsw_ld, rtbit_ld} = 7'b0100000;
    {q_push, q_msg_valid, msg_done, masked_set, loop_fail, cmd_tx} = 6'b000000;
    {end_of_message_flag, start_of_message_flag, msg_chan_b, msg_err} = 4'h0;
    {rt_addr_pin, bc_cond, evt2, bist_flags, msg_cond} = {6'h0b, 7'h00, 14'h0, 12'ha5c, 12'h0};
    {rtsw_in, rtbit_in, retry_cnt, cmd_rta, cmd_sa, cmd_cnt} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_pins();
    t_cfg();
    t_cond();
    t_evt();
    t_ft();
    t_words();
    t_queue();
    print_verdict();
  end
endmodule : tb
